// File: cc_unit.sv
`timescale 1ns/1ps
`default_nettype none
// one capture/compare module working against the shared time base
module cc_unit
    import counter_array_pkg::*;
#(
    parameter int W = CNT_W
) (
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic         tick,     // time base advances this cycle
    input  wire logic [W-1:0] count,    // shared time base
    input  wire logic [2:0]   mode,
    input  wire logic [2:0]   pwm_sel,  // 0..4 -> 8,9,10,11,16 bits
    input  wire logic         cap_rise,
    input  wire logic         cap_fall,
    input  wire logic         cap_in,
    input  wire logic         wr_val,   // load value from software
    input  wire logic [W-1:0] wr_data,
    output logic      [W-1:0] value_ff,
    output logic              cc_out_ff,
    output logic              hit_ff    // one-cycle event pulse
);
    if (W != 16) begin : g_chk
        $error("cc_unit serves a 16-bit time base only");
    end

    logic         cap_d_ff;   // previous capture pin level
    logic         cap_edge;   // selected edge seen
    logic         match;      // full compare hit on a tick
    logic         fmatch;     // low byte hit for frequency output
    logic [W-1:0] mask;       // pwm resolution mask

    // pwm resolution decode; unknown codes fall back to 16 bits
    always_comb begin
        case (pwm_sel)
            3'h0:    mask = 16'h00FF;
            3'h1:    mask = 16'h01FF;
            3'h2:    mask = 16'h03FF;
            3'h3:    mask = 16'h07FF;
            default: mask = 16'hFFFF;
        endcase
    end

    assign cap_edge = (cap_rise & cap_in & ~cap_d_ff)
                    | (cap_fall & ~cap_in & cap_d_ff);
    assign match    = tick && (count == value_ff);
    assign fmatch   = tick && (count[7:0] == value_ff[7:0]);

    // edge detector history
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) cap_d_ff <= 1'b0;
        else          cap_d_ff <= cap_in;
    end

    // capture / compare value; software write wins over hardware
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            value_ff <= 16'h0000;
        end else if (wr_val) begin
            value_ff <= wr_data;
        end else if (mode == MODE_CAP && cap_edge) begin
            value_ff <= count;
        end else if (mode == MODE_FREQ && fmatch) begin
            // next toggle point one half period further on
            value_ff[7:0] <= value_ff[7:0] + value_ff[15:8];
        end
    end

    // module output pin
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cc_out_ff <= 1'b0;
        end else begin
            case (mode)
                MODE_HSO:  if (match) cc_out_ff <= ~cc_out_ff;
                MODE_PWM:  cc_out_ff <= (count & mask)
                                      < (value_ff & mask);
                MODE_FREQ: if (fmatch) cc_out_ff <= ~cc_out_ff;
                default:   cc_out_ff <= 1'b0;
            endcase
        end
    end

    // event pulse per mode
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hit_ff <= 1'b0;
        end else begin
            case (mode)
                MODE_CAP:  hit_ff <= cap_edge;
                MODE_TMR:  hit_ff <= match;
                MODE_HSO:  hit_ff <= match;
                MODE_PWM:  hit_ff <= tick && ((count & mask) == '0);
                MODE_FREQ: hit_ff <= fmatch;
                default:   hit_ff <= 1'b0;
            endcase
        end
    end

    property p_pwm8;
        @(posedge pclk) disable iff (!presetn)
        (mode == MODE_PWM && pwm_sel == 3'h0) |=>
            cc_out_ff == ($past(count[7:0]) < $past(value_ff[7:0]));
    endproperty
    a_pwm8: assert property (p_pwm8)
        else $error("pwm output disagrees with 8-bit compare");

    property p_capture;
        @(posedge pclk) disable iff (!presetn)
        (mode == MODE_CAP && cap_edge && !wr_val) |=>
            (value_ff == $past(count)) && hit_ff;
    endproperty
    a_capture: assert property (p_capture)
        else $error("capture did not latch the time base");
endmodule // cc_unit
`default_nettype wire

// File: counter_array.sv
`timescale 1ns/1ps
`default_nettype none
module counter_array
    import counter_array_pkg::*;
#(
    parameter int N = NUM_MOD
) (
    input  wire logic          pclk,
    input  wire logic          presetn,
    input  wire logic [11:0]   paddr,
    input  wire logic          psel,
    input  wire logic          penable,
    input  wire logic          pwrite,
    input  wire logic [31:0]   pwdata,
    output logic      [31:0]   prdata,
    output logic               pready,
    output logic               pslverr,
    input  wire logic          timer0_ovf,            // one-cycle pulse
    input  wire logic          external_count_input,
    input  wire logic          xosc_clk,              // sampled level
    input  wire logic [N-1:0]  cap_in,                // from crossbar
    output logic      [N-1:0]  cc_out,                // to crossbar
    output logic               irq,
    output logic               wd_reset               // one-cycle pulse
);
    if (N != 3) begin : g_chk
        $error("counter_array is built for three modules");
    end

    // bus side
    logic              acc;          // access phase with ready
    logic              wr;           // write takes effect
    logic [31:0]       prdata_ff;
    logic              pready_ff;
    logic              pslverr_ff;
    logic              hit_addr;     // address maps to a register
    logic [31:0]       rd_mux;
    // control and status
    logic              run_ff;
    logic [2:0]        src_ff;
    logic [CNT_W-1:0]  count_ff;
    logic [ST_W-1:0]   status_ff;
    logic [ST_W-1:0]   enable_ff;
    logic [ST_W-1:0]   set_ev;       // hardware events this cycle
    logic [ST_W-1:0]   clr_ev;       // software clears this cycle
    logic              irq_ff;
    logic              wd_en_ff;
    logic [7:0]        wd_lim_ff;
    logic              wd_reset_ff;
    logic              boot_ff;      // high only in first cycle
    // tick generation
    logic [3:0]        div_slow_ff;
    logic [1:0]        div_fast_ff;
    logic [2:0]        div_xosc_ff;
    logic              ext_d_ff;
    logic              xosc_d_ff;
    logic              xosc_edge;
    logic              tick_slow;
    logic              tick_fast;
    logic              tick_xosc;
    logic              tick_ext;
    logic              tick_src;     // selected source ticks
    logic              tick;         // time base advances
    // module side
    logic [7:0]        mode_ff   [N];
    logic [CNT_W-1:0]  value     [N];
    logic [N-1:0]      hit;
    logic [N-1:0]      cc_q;
    logic [N-1:0]      wr_val;
    logic [CNT_W-1:0]  wr_data   [N];
    logic [2:0]        mode_eff  [N];

    // APB: zero-wait slave, ready in the first access cycle
    assign acc = psel & penable & pready_ff;
    assign wr  = acc & pwrite;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff  <= 32'h0000_0000;
        end else begin
            pready_ff  <= psel & ~penable;
            pslverr_ff <= psel & ~penable & ~hit_addr;
            // read data captured at setup, stable through access
            if (psel & ~penable & ~pwrite) prdata_ff <= rd_mux;
        end
    end
    assign pready  = pready_ff;
    assign pslverr = pslverr_ff;
    assign prdata  = prdata_ff;

    // address decode and read mux; unmapped reads return zero
    always_comb begin
        hit_addr = 1'b1;
        rd_mux   = 32'h0000_0000;
        case (paddr)
            OFF_CTRL:   rd_mux = {28'h0, src_ff, run_ff};
            OFF_COUNT:  rd_mux = {16'h0, count_ff};
            OFF_STATUS: rd_mux = {27'h0, status_ff};
            OFF_CLEAR:  rd_mux = 32'h0000_0000;  // write-only
            OFF_ENABLE: rd_mux = {27'h0, enable_ff};
            OFF_WDOG:   rd_mux = {16'h0, wd_lim_ff, 7'h0, wd_en_ff};
            default:    hit_addr = 1'b0;
        endcase
        for (int i = 0; i < N; i++) begin
            if (paddr == OFF_MODE0 + 12'(i) * OFF_STRIDE) begin
                hit_addr = 1'b1;
                rd_mux   = {24'h0, mode_ff[i]};
            end
            if (paddr == OFF_VALUE0 + 12'(i) * OFF_STRIDE) begin
                hit_addr = 1'b1;
                rd_mux   = {16'h0, value[i]};
            end
        end
    end

    // run bit and clock source select
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run_ff <= 1'b0;
            src_ff <= SRC_SLOW;
        end else if (wr && paddr == OFF_CTRL) begin
            run_ff <= pwdata[CTRL_RUN];
            // codes past the last source select nothing
            src_ff <= pwdata[CTRL_SRC +: 3];
        end
    end

    // divide-by-12 and divide-by-4 of the system clock
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_slow_ff <= 4'h0;
            div_fast_ff <= 2'h0;
        end else begin
            div_slow_ff <= tick_slow ? 4'h0 : div_slow_ff + 4'h1;
            div_fast_ff <= div_fast_ff + 2'h1;
        end
    end
    assign tick_slow = (div_slow_ff == 4'(DIV_SLOW - 1));
    assign tick_fast = (div_fast_ff == 2'(DIV_FAST - 1));

    // external count input and external oscillator edge detect;
    // the oscillator must be slower than half the system clock
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_d_ff    <= 1'b0;
            xosc_d_ff   <= 1'b0;
            div_xosc_ff <= 3'h0;
        end else begin
            ext_d_ff  <= external_count_input;
            xosc_d_ff <= xosc_clk;
            if (xosc_edge) div_xosc_ff <= div_xosc_ff + 3'h1;
        end
    end
    assign tick_ext  = external_count_input & ~ext_d_ff;
    assign xosc_edge = xosc_clk & ~xosc_d_ff;
    assign tick_xosc = xosc_edge && div_xosc_ff == 3'(DIV_XOSC - 1);

    // source select
    always_comb begin
        case (src_ff)
            SRC_SLOW: tick_src = tick_slow;
            SRC_FAST: tick_src = tick_fast;
            SRC_TMR0: tick_src = timer0_ovf;
            SRC_EXT:  tick_src = tick_ext;
            SRC_SYS:  tick_src = 1'b1;
            SRC_XOSC: tick_src = tick_xosc;
            default:  tick_src = 1'b0;
        endcase
    end
    assign tick = run_ff & tick_src;

    // shared time base; a software load wins over counting
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) count_ff <= 16'h0000;
        else if (wr && paddr == OFF_COUNT) count_ff <= pwdata[15:0];
        else if (tick) count_ff <= count_ff + 16'h0001;
    end

    // module mode registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < N; i++) mode_ff[i] <= 8'h00;
        end else begin
            for (int i = 0; i < N; i++) begin
                if (wr && paddr == OFF_MODE0 + 12'(i) * OFF_STRIDE)
                    mode_ff[i] <= pwdata[7:0];
            end
        end
    end

    // watchdog control; enabled straight out of reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wd_en_ff  <= 1'b1;
            wd_lim_ff <= WD_LIM_RST;
            boot_ff   <= 1'b1;
        end else begin
            boot_ff <= 1'b0;
            if (wr && paddr == OFF_WDOG) begin
                wd_en_ff  <= pwdata[WD_EN];
                wd_lim_ff <= pwdata[WD_LIM +: 8];
            end
        end
    end

    // value writes; a kick reloads module 2 ahead of the base
    always_comb begin
        for (int i = 0; i < N; i++) begin
            wr_val[i]  = wr && paddr == OFF_VALUE0 + 12'(i) * OFF_STRIDE;
            wr_data[i] = pwdata[15:0];
            mode_eff[i] = mode_ff[i][2:0];
        end
        if (wr && paddr == OFF_WDOG && pwdata[WD_KICK]) begin
            wr_val[WD_MOD]  = 1'b1;
            wr_data[WD_MOD] = count_ff + {pwdata[WD_LIM +: 8], 8'h00};
        end
        // in the watchdog role module 2 is a plain compare timer
        if (wd_en_ff) mode_eff[WD_MOD] = MODE_TMR;
    end

    // the three modules
    for (genvar g = 0; g < N; g++) begin : g_mod
        cc_unit #(.W(CNT_W)) u_cc (
            .pclk     (pclk),
            .presetn  (presetn),
            .tick     (tick),
            .count    (count_ff),
            .mode     (mode_eff[g]),
            .pwm_sel  (mode_ff[g][MD_PWM +: 3]),
            .cap_rise (mode_ff[g][MD_RISE]),
            .cap_fall (mode_ff[g][MD_FALL]),
            .cap_in   (cap_in[g]),
            .wr_val   (wr_val[g]),
            .wr_data  (wr_data[g]),
            .value_ff (value[g]),
            .cc_out_ff(cc_q[g]),
            .hit_ff   (hit[g])
        );
    end
    assign cc_out = cc_q;

    // watchdog expiry: compare hit while enabled
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) wd_reset_ff <= 1'b0;
        else          wd_reset_ff <= wd_en_ff & hit[WD_MOD];
    end
    assign wd_reset = wd_reset_ff;

    // sticky status; a set in the clearing cycle wins
    assign set_ev = {wd_en_ff & hit[WD_MOD],
                     hit & {~wd_en_ff, 2'b11},
                     tick && count_ff == 16'hFFFF};
    assign clr_ev = (wr && paddr == OFF_CLEAR) ? pwdata[ST_W-1:0]
                                               : '0;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) status_ff <= '0;
        else          status_ff <= (status_ff & ~clr_ev) | set_ev;
    end

    // interrupt enable and level output
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            enable_ff <= '0;
            irq_ff    <= 1'b0;
        end else begin
            if (wr && paddr == OFF_ENABLE) enable_ff <= pwdata[ST_W-1:0];
            irq_ff <= |(status_ff & enable_ff);
        end
    end
    assign irq = irq_ff;

    property p_count;
        @(posedge pclk) disable iff (!presetn)
        (tick && !(wr && paddr == OFF_COUNT)) |=>
            count_ff == $past(count_ff) + 16'h0001;
    endproperty
    a_count: assert property (p_count)
        else $error("time base did not advance by one");

    property p_wrap;
        @(posedge pclk) disable iff (!presetn)
        (tick && count_ff == 16'hFFFF && !wr) |=>
            count_ff == 16'h0000 && status_ff[ST_OVF];
    endproperty
    a_wrap: assert property (p_wrap)
        else $error("wrap did not reach zero with overflow set");

    property p_slow;
        @(posedge pclk) disable iff (!presetn)
        tick_slow |=> !tick_slow [*8] ##1 !tick_slow ##1 !tick_slow
                      ##1 !tick_slow ##1 tick_slow;
    endproperty
    a_slow: assert property (p_slow)
        else $error("slow divider is not twelve cycles");

    property p_fast;
        @(posedge pclk) disable iff (!presetn)
        tick_fast |=> !tick_fast [*3] ##1 tick_fast;
    endproperty
    a_fast: assert property (p_fast)
        else $error("fast divider is not four cycles");

    property p_boot;
        @(posedge pclk) disable iff (!presetn)
        boot_ff |-> wd_en_ff && mode_eff[WD_MOD] == MODE_TMR;
    endproperty
    a_boot: assert property (p_boot)
        else $error("watchdog not enabled after reset");

    property p_wdog;
        @(posedge pclk) disable iff (!presetn)
        (wd_en_ff && hit[WD_MOD]) |=> wd_reset_ff ##1 !wd_reset_ff;
    endproperty
    a_wdog: assert property (p_wdog)
        else $error("watchdog expiry pulse missing or too long");

    property p_xosc;
        @(posedge pclk) disable iff (!presetn)
        (run_ff && src_ff == SRC_XOSC && tick_src) |->
            xosc_edge && div_xosc_ff == 3'h7;
    endproperty
    a_xosc: assert property (p_xosc)
        else $error("oscillator tick not on eighth edge");

    property p_ready;
        @(posedge pclk) disable iff (!presetn)
        (psel && !penable) |=> pready_ff ##1 !pready_ff;
    endproperty
    a_ready: assert property (p_ready)
        else $error("bus ready not a single access cycle");
endmodule // counter_array
`default_nettype wire

// File: counter_array_capture_compare_bench.sv
`timescale 1ns/1ps
`default_nettype none
module counter_array_capture_compare_bench import counter_array_pkg::*;;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic        t0, ext, xo, irq, wd_reset, e, b;
    logic [2:0]  cap_req, cap_pin, cc_out;
    int          fails, n_compared, hi;
    typedef struct packed {logic [11:0] a; logic [31:0] d; logic err;} row_t;
    row_t        rows [8];  // address, value after reset, refusal
    int          dv [7] = '{12, 4, 6, 6, 1, 32, 0};  // cycles per tick
    always #5 pclk = ~pclk;
    counter_array i_counter_array (.pclk(pclk), .presetn(presetn),
        .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .timer0_ovf(t0), .external_count_input(ext),
        .xosc_clk(xo), .cap_in(cap_pin), .cc_out(cc_out), .irq(irq),
        .wd_reset(wd_reset));
    far_side_model i_far_side_model (.pclk(pclk), .presetn(presetn),
        .cap_req(cap_req), .timer0_ovf(t0), .external_count_input(ext),
        .xosc_clk(xo), .cap_pin(cap_pin));
    task automatic chk(input string nm, input logic [31:0] x,
                       input logic [31:0] g);
        n_compared++;
        if (g !== x) begin
            fails++;
            $display("ERROR %s expected %h seen %h", nm, x, g);
        end
    endtask
    // one transfer, entered just after a rising edge; idles one cycle after
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 50) chk("pready", 1, 0);
        @(posedge pclk);
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rd(input logic [11:0] a);
        apb(1'b0, a, 32'h0);
    endtask
    task automatic check_regs();
        foreach (rows[i]) begin
            rd(rows[i].a);
            chk("reg", rows[i].d, q);
            chk("slverr", {31'h0, rows[i].err}, {31'h0, e});
        end
    endtask
    task automatic look(input string nm, input logic x, input int cy);
        repeat (cy) @(negedge pclk);
        chk(nm, {31'h0, x}, {31'h0, irq});
        @(posedge pclk);
    endtask
    task automatic print_verdict();
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        {pclk, presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        cap_req = 3'h0;
        rows = '{{OFF_CTRL, 32'h0, 1'b0}, {OFF_COUNT, 32'h0, 1'b0},
                 {OFF_STATUS, 32'h0, 1'b0}, {OFF_ENABLE, 32'h0, 1'b0},
                 {OFF_WDOG, 32'h0000FF01, 1'b0}, {OFF_MODE0, 32'h0, 1'b0},
                 {OFF_VALUE0, 32'h0, 1'b0}, {12'h100, 32'h0, 1'b1}};
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        check_regs();
        $display("reset values done");
        // watchdog armed by reset fires when the base wraps to its value
        wr(OFF_COUNT, 32'h0000FFF0);
        wr(OFF_CTRL, {28'h0, SRC_SYS, 1'b1});
        b = 1'b0;
        repeat (40) @(negedge pclk) if (wd_reset === 1'b1) b = 1'b1;
        @(posedge pclk);
        chk("wd_reset", 1, {31'h0, b});
        rd(OFF_STATUS);
        chk("status", 32'h11, q);
        wr(OFF_ENABLE, 32'h1);
        look("irq set", 1'b1, 3);
        wr(OFF_ENABLE, 32'h0);
        look("irq masked", 1'b0, 3);
        wr(OFF_ENABLE, 32'h1);
        wr(OFF_CLEAR, 32'h1F);
        look("irq cleared", 1'b0, 3);
        // a kick with the base stopped reloads module 2 a limit ahead
        wr(OFF_CTRL, 32'h0);
        wr(OFF_WDOG, 32'h00001003);
        rd(OFF_COUNT);
        hi = q;
        rd(OFF_VALUE0 + OFF_STRIDE + OFF_STRIDE);
        chk("kick", (hi + 32'h1000) & 32'hFFFF, q);
        wr(OFF_WDOG, 32'h0);
        $display("watchdog and irq done");
        // each source over a fixed window; code 6 must not count
        for (int i = 0; i < 7; i++) begin
            wr(OFF_CTRL, 32'h0);
            wr(OFF_COUNT, 32'h0);
            wr(OFF_CTRL, {28'h0, i[2:0], 1'b1});
            repeat (190) @(posedge pclk);
            wr(OFF_CTRL, 32'h0);
            rd(OFF_COUNT);
            hi = (dv[i] == 0) ? 0 : 193 / dv[i];
            if (dv[i] == 0) chk("count off", 32'h0, q);
            else chk("count", hi, (q + 2 - hi <= 4) ? hi : q);
        end
        $display("clock sources done");
        // fast output toggles once at its match; module 1 captures an edge
        wr(OFF_CLEAR, 32'h1F);
        wr(OFF_COUNT, 32'h0);
        wr(OFF_VALUE0, 32'h5);
        wr(OFF_MODE0, {29'h0, MODE_HSO});
        wr(OFF_MODE0 + OFF_STRIDE, 32'h41);
        b = cc_out[0];
        wr(OFF_CTRL, {28'h0, SRC_SYS, 1'b1});
        cap_req <= 3'h2;
        repeat (20) @(posedge pclk);
        chk("toggle", {31'h0, ~b}, {31'h0, cc_out[0]});
        rd(OFF_STATUS);
        chk("events", 32'h06, q);
        // 8-bit pwm at a quarter duty over one whole period
        wr(OFF_VALUE0, 32'h40);
        wr(OFF_MODE0, {29'h0, MODE_PWM});
        hi = 0;
        repeat (256) @(negedge pclk) hi += int'(cc_out[0]);
        @(posedge pclk);
        chk("pwm high", 32'd64, hi);
        // frequency output: low byte steps by ten, one toggle per ten ticks
        wr(OFF_CTRL, 32'h0);
        wr(OFF_COUNT, 32'h0);
        wr(OFF_VALUE0, 32'h00000A05);
        wr(OFF_MODE0, {29'h0, MODE_FREQ});
        wr(OFF_CTRL, {28'h0, SRC_SYS, 1'b1});
        repeat (20) @(posedge pclk);
        hi = 0;
        @(negedge pclk) b = cc_out[0];
        repeat (100) @(negedge pclk) begin
            hi += int'(cc_out[0] != b);
            b = cc_out[0];
        end
        @(posedge pclk);
        chk("freq toggles", 32'd10, hi);
        $display("module modes done");
        presetn <= 1'b0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        check_regs();
        $display("second reset done");
        print_verdict();
    end
    // cut a hang short well past the expected run length
    initial begin
        repeat (20000) @(posedge pclk);
        fails++;
        print_verdict();
    end
endmodule // counter_array_capture_compare_bench
`default_nettype wire

// File: counter_array_pkg.sv
package counter_array_pkg;
    // time base and module count
    localparam int CNT_W    = 16;
    localparam int NUM_MOD  = 3;
    localparam int WD_MOD   = 2;
    // clock source dividers
    localparam int DIV_SLOW = 12;
    localparam int DIV_FAST = 4;
    localparam int DIV_XOSC = 8;
    // register byte offsets
    localparam logic [11:0] OFF_CTRL   = 12'h000;
    localparam logic [11:0] OFF_COUNT  = 12'h004;
    localparam logic [11:0] OFF_STATUS = 12'h008;
    localparam logic [11:0] OFF_CLEAR  = 12'h00C;
    localparam logic [11:0] OFF_ENABLE = 12'h010;
    localparam logic [11:0] OFF_WDOG   = 12'h014;
    localparam logic [11:0] OFF_MODE0  = 12'h020;
    localparam logic [11:0] OFF_VALUE0 = 12'h030;
    localparam logic [11:0] OFF_STRIDE = 12'h004;
    // control fields
    localparam int CTRL_RUN   = 0;
    localparam int CTRL_SRC   = 1;
    // clock source codes
    localparam logic [2:0] SRC_SLOW  = 3'h0;
    localparam logic [2:0] SRC_FAST  = 3'h1;
    localparam logic [2:0] SRC_TMR0  = 3'h2;
    localparam logic [2:0] SRC_EXT   = 3'h3;
    localparam logic [2:0] SRC_SYS   = 3'h4;
    localparam logic [2:0] SRC_XOSC  = 3'h5;
    // module mode codes and mode register fields
    localparam logic [2:0] MODE_OFF  = 3'h0;
    localparam logic [2:0] MODE_CAP  = 3'h1;
    localparam logic [2:0] MODE_TMR  = 3'h2;
    localparam logic [2:0] MODE_HSO  = 3'h3;
    localparam logic [2:0] MODE_PWM  = 3'h4;
    localparam logic [2:0] MODE_FREQ = 3'h5;
    localparam int MD_PWM  = 3;
    localparam int MD_RISE = 6;
    localparam int MD_FALL = 7;
    // status bits
    localparam int ST_OVF  = 0;
    localparam int ST_HIT  = 1;
    localparam int ST_WDOG = 4;
    localparam int ST_W    = 5;
    // watchdog register fields and reset values
    localparam int WD_EN   = 0;
    localparam int WD_KICK = 1;
    localparam int WD_LIM  = 8;
    localparam logic [7:0] WD_LIM_RST = 8'hFF;
endpackage

// File: far_side_model.sv
`timescale 1ns/1ps
`default_nettype none
// pins beyond the crossbar and the slow count sources of the time base
module far_side_model (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic [2:0] cap_req,              // levels the bench asks for
    output logic            timer0_ovf,
    output logic            external_count_input,
    output logic            xosc_clk,
    output logic      [2:0] cap_pin
);
    logic [3:0] ph_ff;  // 12-cycle phase shared by all sources
    // these sources run free, so nothing stands still between frames
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ph_ff                <= 4'h0;
            timer0_ovf           <= 1'b0;
            external_count_input <= 1'b0;
            xosc_clk             <= 1'b0;
            cap_pin              <= 3'h0;
        end else begin
            ph_ff                <= (ph_ff == 4'hB) ? 4'h0 : ph_ff + 4'h1;
            timer0_ovf           <= (ph_ff == 4'h0) || (ph_ff == 4'h6);
            external_count_input <= (ph_ff % 4'h6) < 4'h3;
            xosc_clk             <= ph_ff[1]; // slow enough to sample
            cap_pin              <= cap_req;
        end
    end
endmodule // far_side_model
`default_nettype wire
